/* rco_pkg.sv */
package rco_pkg;

  localparam logic [7:0] RCO_PROGRAM_FLAG_REG_ADDR = 8'h86;
  localparam int RCO_BIT_TIMEOUT_N = 7;
  localparam int RCO_BIT_POWERDOWN_N = 6;
  localparam int RCO_BIT_LV_HIGH = 5;
  localparam int RCO_BIT_LV_MID = 4;
  localparam int RCO_BIT_CARRY = 2;
  localparam int RCO_BIT_DCARRY = 1;
  localparam int RCO_BIT_ZERO = 0;
  localparam logic [2:0] RCO_ALU_RST = 3'h0;
  localparam logic [7:0] RCO_MASK_RW = 8'h07;

  // Control and option register placed beside the flag register.
  localparam logic [7:0] RCO_CTRL_ADDR = 8'h87;
  localparam logic [7:0] RCO_CTRL_RST = 8'h00;
  localparam logic [7:0] RCO_STAT_ADDR = 8'h88;

  // Cause codes held in the two top flag bits.
  localparam logic [1:0] RCO_CAUSE_WDT = 2'b00;
  localparam logic [1:0] RCO_CAUSE_POR = 2'b10;
  localparam logic [1:0] RCO_CAUSE_EXT = 2'b11;

  // Divider codes: instruction cycle is 2**code oscillator clocks.
  localparam logic [2:0] RCO_DIV1 = 3'h0;
  localparam logic [2:0] RCO_DIV2 = 3'h1;
  localparam logic [2:0] RCO_DIV4 = 3'h2;
  localparam logic [2:0] RCO_DIV128 = 3'h7;

  // Times in nanoseconds, converted to mclk_i cycles at 25 ns.
  localparam int RCO_CLK_NS = 25;
  localparam int RCO_SUPPLY_NS = 1000;
  localparam int RCO_WARMUP_NS = 2000;
  localparam int RCO_SUPPLY_CYC = (RCO_SUPPLY_NS + RCO_CLK_NS - 1) / RCO_CLK_NS;
  localparam int RCO_WARMUP_CYC = (RCO_WARMUP_NS + RCO_CLK_NS - 1) / RCO_CLK_NS;
  localparam int RCO_CNT_W = 12;

  typedef enum logic [2:0] {
    RCO_ST_POWERUP = 3'b000,
    RCO_ST_PINWAIT = 3'b001,
    RCO_ST_INIT = 3'b011,
    RCO_ST_WARMUP = 3'b010,
    RCO_ST_RUN = 3'b110
  } rco_state_e;

  typedef struct packed {
    logic fast_clk_over_2m;
    logic fast_clk_over_4m;
    logic low_power;
    logic noise_filter;
    logic reset_pin_en;
    logic security;
    logic slow_mode;
    logic [2:0] div_code;
  } rco_opt_s;

endpackage : rco_pkg

/* rco_reset_ctrl.sv */
`timescale 1ns/1ps
// Function
// [RQ1] Divider option sets the instruction cycle only in normal fast-clock mode.
// [RQ2] Slow mode forces instruction cycle to slow RC clock divided by four; opt.slow_mode is tied to 0, so slow mode is never entered.
// [RQ3] Noise filter on limits divider to divide-by-4 through divide-by-128.
// [RQ4] Noise filter off also allows divide-by-1 and divide-by-2.
// [RQ5] With low power, software keeps instruction rate at or under 2 MIPS.
// [RQ6] Low power, filter off, 2 to 4 MHz clock allows divide-by-2 upward.
// [RQ7] With reset function chosen, a pin falling edge resets the system.
// [RQ8] With input function chosen, pin is only port 1 input bit 5.
// [RQ9] Security on blocks dumping the full program memory.
// [RQ10] Reset on power-on, watchdog, brown-out, and external pin when enabled.
// [RQ11] Any reset restores registers, halts execution and clears the counter; ctrl and icycle_div_o are restored only by rst_i.
// [RQ12] After release, fetching starts at address zero.
// [RQ13] Flag bits 7:6 code cause: 00 watchdog, 10 power-on, 11 pin.
// [RQ14] Power-on first waits for the supply to become stable.
// [RQ15] With pin enabled, stay in reset while pin is low.
// [RQ16] After initialisation, wait for oscillator warm-up before running.
// [RQ17] Watchdog reset: overflow, initialise, warm up, then run.
// [RQ18] After a watchdog reset, return to normal operating mode.
// [RQ19] Power-on reset comes from the low-voltage detector indication.
// [RQ20] Any low-voltage reset clears both low-voltage indicator flags.
// [RQ21] Pin is active low: run while high, reset while low.
// [RQ22] Instruction cycle spans the selected number of clocks, up to 128.
// [RQ23] Asynchronous reset requests are synchronised; release is synchronous.
module rco_reset_ctrl
  import rco_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic lvd_reset_i,
  input wire logic brownout_i,
  input wire logic wdt_overflow_i,
  input wire logic reset_pin_i,
  input wire logic supply_ok_i,
  input wire logic lv_mid_i,
  input wire logic lv_high_i,
  input wire logic osc_ready_i,
  input wire logic rom_dump_req_i,
  output logic sys_reset_o,
  output logic cpu_run_o,
  output logic [7:0] pc_start_o,
  output logic port1_bit5_o,
  output logic icycle_tick_o,
  output logic [2:0] icycle_div_o,
  output logic opt_error_o,
  output logic rom_dump_en_o,
  output logic normal_mode_o
);

  logic [2:0] pin_sync;
  logic [2:0] lvd_sync;
  logic [2:0] bo_sync;
  logic [2:0] wdt_sync;
  logic [2:0] sup_sync;
  logic pin_lvl;
  logic lvd_lvl;
  logic bo_lvl;
  logic wdt_lvl;
  logic sup_lvl;
  logic pin_prev;
  rco_state_e state;
  logic [RCO_CNT_W-1:0] cnt;
  logic [7:0] ctrl;
  rco_opt_s opt;
  logic [1:0] cause;
  logic [2:0] alu_flags;
  logic lv_mid_flag;
  logic lv_high_flag;
  logic [6:0] div_cnt;
  logic [2:0] eff_div;
  logic [2:0] min_div;
  logic pin_fall;
  logic any_reset;

  function automatic logic agree(input logic [2:0] s, input logic prev);
    agree = (s[1] == s[2]) ? s[2] : prev;
  endfunction : agree

  // Smallest divider code that an option byte permits; used on write and for checking.
  function automatic logic [2:0] floor_div(input logic [7:0] c);
    if (c[4]) begin
      floor_div = RCO_DIV4; // RQ3
    end else if (c[5] && c[6]) begin
      floor_div = RCO_DIV4;
    end else if (c[5] && c[7]) begin
      floor_div = RCO_DIV2; // RQ6
    end else begin
      floor_div = RCO_DIV1; // RQ4
    end
  endfunction : floor_div

  assign opt.fast_clk_over_2m = ctrl[7];
  assign opt.fast_clk_over_4m = ctrl[6];
  assign opt.low_power = ctrl[5];
  assign opt.noise_filter = ctrl[4];
  assign opt.reset_pin_en = ctrl[3];
  assign opt.security = ctrl[2];
  assign opt.slow_mode = 1'b0;
  assign opt.div_code = wdata_i[2:0];

  // Reset request, supply and pin inputs pass three flops; the third and second must agree.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_sync <= 3'h7;
      lvd_sync <= 3'h7;
      bo_sync <= 3'h0;
      wdt_sync <= 3'h0;
      sup_sync <= 3'h0;
    end else if (clk_en_i) begin
      pin_sync <= {pin_sync[1:0], reset_pin_i}; // RQ23
      lvd_sync <= {lvd_sync[1:0], lvd_reset_i}; // RQ23
      bo_sync <= {bo_sync[1:0], brownout_i}; // RQ23
      wdt_sync <= {wdt_sync[1:0], wdt_overflow_i}; // RQ23
      sup_sync <= {sup_sync[1:0], supply_ok_i}; // RQ23
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_lvl <= 1'b1;
      lvd_lvl <= 1'b1;
      bo_lvl <= 1'b0;
      wdt_lvl <= 1'b0;
      sup_lvl <= 1'b0;
      pin_prev <= 1'b1;
    end else if (clk_en_i) begin
      pin_lvl <= agree(pin_sync, pin_lvl);
      lvd_lvl <= agree(lvd_sync, lvd_lvl);
      bo_lvl <= agree(bo_sync, bo_lvl);
      wdt_lvl <= agree(wdt_sync, wdt_lvl);
      sup_lvl <= agree(sup_sync, sup_lvl);
      pin_prev <= pin_lvl;
    end
  end

  assign pin_fall = opt.reset_pin_en && pin_prev && !pin_lvl; // RQ7 RQ21
  assign any_reset = lvd_lvl || bo_lvl || wdt_lvl || pin_fall; // RQ10 RQ19

  // Reset sequencer.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= RCO_ST_POWERUP;
      cnt <= '0;
    end else if (clk_en_i) begin
      if (lvd_lvl || bo_lvl) begin
        state <= RCO_ST_POWERUP; // RQ10 RQ19
        cnt <= '0;
      end else if (wdt_lvl) begin
        state <= RCO_ST_INIT; // RQ17
        cnt <= '0;
      end else if (pin_fall) begin
        state <= RCO_ST_PINWAIT; // RQ7
        cnt <= '0;
      end else begin
        unique case (state)
          RCO_ST_POWERUP: begin
            if (!sup_lvl) begin
              cnt <= '0;
            end else if (cnt >= RCO_CNT_W'(RCO_SUPPLY_CYC - 1)) begin
              state <= RCO_ST_PINWAIT; // RQ14
              cnt <= '0;
            end else begin
              cnt <= cnt + 1'b1;
            end
          end
          RCO_ST_PINWAIT: begin
            if (!opt.reset_pin_en || pin_lvl) begin
              state <= RCO_ST_INIT; // RQ15 RQ21
            end
          end
          RCO_ST_INIT: begin
            state <= RCO_ST_WARMUP; // RQ11
            cnt <= '0;
          end
          RCO_ST_WARMUP: begin
            if (osc_ready_i && cnt >= RCO_CNT_W'(RCO_WARMUP_CYC - 1)) begin
              state <= RCO_ST_RUN; // RQ16 RQ18
            end else if (cnt < RCO_CNT_W'(RCO_WARMUP_CYC - 1)) begin
              cnt <= cnt + 1'b1;
            end
          end
          RCO_ST_RUN: begin
            cnt <= '0;
          end
        endcase
      end
    end
  end

  // Reset cause flags.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cause <= RCO_CAUSE_POR;
    end else if (clk_en_i) begin
      if (lvd_lvl || bo_lvl) begin
        cause <= RCO_CAUSE_POR; // RQ13
      end else if (wdt_lvl) begin
        cause <= RCO_CAUSE_WDT; // RQ13
      end else if (pin_fall) begin
        cause <= RCO_CAUSE_EXT; // RQ13
      end else if (wr_i && addr_i == RCO_PROGRAM_FLAG_REG_ADDR) begin
        cause <= {wdata_i[RCO_BIT_TIMEOUT_N], wdata_i[RCO_BIT_POWERDOWN_N]};
      end
    end
  end

  // Low-voltage indicators follow the detector, cleared by any reset.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      lv_mid_flag <= 1'b0;
      lv_high_flag <= 1'b0;
    end else if (clk_en_i) begin
      if (lvd_lvl || bo_lvl || state != RCO_ST_RUN) begin
        lv_mid_flag <= 1'b0; // RQ20
        lv_high_flag <= 1'b0; // RQ20
      end else begin
        lv_mid_flag <= lv_mid_i;
        lv_high_flag <= lv_high_i;
      end
    end
  end

  // Arithmetic flags restored on every reset; option control restored only by rst_i.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      alu_flags <= RCO_ALU_RST;
      ctrl <= RCO_CTRL_RST;
      icycle_div_o <= RCO_DIV4;
    end else if (clk_en_i) begin
      if (any_reset) begin
        alu_flags <= RCO_ALU_RST; // RQ11
      end else if (wr_i && addr_i == RCO_PROGRAM_FLAG_REG_ADDR) begin
        alu_flags <= wdata_i[2:0] & RCO_MASK_RW[2:0];
      end
      if (wr_i && addr_i == RCO_CTRL_ADDR) begin
        ctrl <= {wdata_i[7:3], wdata_i[2] | ctrl[2], 2'b00};
        // The clamp follows the options written in the same cycle, not the old ones.
        icycle_div_o <= (wdata_i[2:0] < floor_div(wdata_i)) ? floor_div(wdata_i) : wdata_i[2:0]; // RQ3
      end
    end
  end

  // Smallest divider code the present option set permits.
  assign min_div = floor_div(ctrl); // RQ3 RQ4 RQ6

  assign eff_div = opt.slow_mode ? RCO_DIV4 : icycle_div_o; // RQ1 RQ2

  // Instruction-cycle tick every 2**code oscillator clocks.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      div_cnt <= '0;
      icycle_tick_o <= 1'b0;
    end else if (clk_en_i) begin
      if (state != RCO_ST_RUN || any_reset) begin
        div_cnt <= '0; // RQ11
        icycle_tick_o <= 1'b0;
      end else if (div_cnt >= 7'((1 << eff_div) - 1)) begin
        div_cnt <= '0; // RQ22
        icycle_tick_o <= 1'b1;
      end else begin
        div_cnt <= div_cnt + 1'b1;
        icycle_tick_o <= 1'b0;
      end
    end
  end

  // Status outputs and register read port.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      sys_reset_o <= 1'b1;
      cpu_run_o <= 1'b0;
      pc_start_o <= 8'h00;
      port1_bit5_o <= 1'b0;
      opt_error_o <= 1'b0;
      rom_dump_en_o <= 1'b0;
      normal_mode_o <= 1'b0;
      rdata_o <= 8'h00;
    end else if (clk_en_i) begin
      sys_reset_o <= any_reset || state != RCO_ST_RUN; // RQ11 RQ23
      cpu_run_o <= !any_reset && state == RCO_ST_RUN; // RQ12 RQ18
      pc_start_o <= 8'h00; // RQ12
      port1_bit5_o <= opt.reset_pin_en ? 1'b0 : pin_lvl; // RQ8
      opt_error_o <= icycle_div_o < min_div;
      rom_dump_en_o <= rom_dump_req_i && !opt.security; // RQ9
      normal_mode_o <= !any_reset && state == RCO_ST_RUN && !opt.slow_mode; // RQ18
      rdata_o <= 8'h00;
      if (rd_i) begin
        unique case (addr_i)
          RCO_PROGRAM_FLAG_REG_ADDR: rdata_o <= {cause, lv_high_flag, lv_mid_flag, 1'b0, alu_flags};
          RCO_CTRL_ADDR: rdata_o <= {ctrl[7:2], 2'b00};
          RCO_STAT_ADDR: rdata_o <= {2'b00, state, icycle_div_o};
          default: rdata_o <= 8'h00;
        endcase
      end
    end
  end

endmodule : rco_reset_ctrl

/* rco_reset_ctrl_props.sv */
`timescale 1ns/1ps
module rco_reset_ctrl_props
  import rco_pkg::*;
(
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic lvd_reset_i,
  input wire logic wdt_overflow_i,
  input wire logic osc_ready_i,
  input wire logic rom_dump_req_i,
  input wire logic sys_reset_o,
  input wire logic cpu_run_o,
  input wire logic [7:0] pc_start_o,
  input wire logic icycle_tick_o,
  input wire logic [2:0] icycle_div_o,
  input wire logic rom_dump_en_o,
  input wire logic normal_mode_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  pc_zero_a: assert property (pc_start_o == 8'h00) else $error("start address not zero");
  halt_reset_a: assert property (sys_reset_o |-> !cpu_run_o && !icycle_tick_o)
    else $error("running while in reset");
  mode_run_a: assert property (normal_mode_o == cpu_run_o) else $error("mode differs");
  lvd_reset_a: assert property (lvd_reset_i [*4] |-> ##[0:6] sys_reset_o)
    else $error("low voltage did not reset");
  wdt_reset_a: assert property (wdt_overflow_i [*4] |-> ##[0:6] sys_reset_o)
    else $error("watchdog did not reset");
  warm_osc_a: assert property ($rose(cpu_run_o) |-> $past(osc_ready_i))
    else $error("run before oscillator ready");
  tick_div_a: assert property (icycle_tick_o && icycle_div_o != RCO_DIV1 |=> !icycle_tick_o)
    else $error("ticks too close");
  rd_quiet_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00) else $error("read data stale");
  dump_req_a: assert property (rom_dump_en_o |-> $past(rom_dump_req_i))
    else $error("dump without request");
endmodule : rco_reset_ctrl_props
bind rco_reset_ctrl rco_reset_ctrl_props u_props (.mclk_i(mclk_i), .rst_i(rst_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .lvd_reset_i(lvd_reset_i), .wdt_overflow_i(wdt_overflow_i),
  .osc_ready_i(osc_ready_i), .rom_dump_req_i(rom_dump_req_i), .sys_reset_o(sys_reset_o),
  .cpu_run_o(cpu_run_o), .pc_start_o(pc_start_o), .icycle_tick_o(icycle_tick_o),
  .icycle_div_o(icycle_div_o), .rom_dump_en_o(rom_dump_en_o), .normal_mode_o(normal_mode_o));

/* rco_far_side.sv */
`timescale 1ns/1ps
module rco_far_side (
  input wire logic mclk_i,
  input wire logic pwr_fail_i,
  input wire logic pin_low_i,
  input wire logic wdt_cmd_i,
  output logic lvd_o,
  output logic supply_ok_o,
  output logic pin_o,
  output logic osc_ok_o,
  output logic wdt_o
);
  logic [4:0] warm = 5'h00;
  // The pin has a pull-up, so it rests high unless pulled low.
  assign pin_o = !pin_low_i;
  assign lvd_o = pwr_fail_i;
  assign supply_ok_o = !pwr_fail_i;
  assign wdt_o = wdt_cmd_i;
  // The oscillator needs some cycles of good supply before it is ready.
  always @(posedge mclk_i) begin
    warm <= pwr_fail_i ? 5'h00 : (warm == 5'h1F ? warm : warm + 5'h01);
  end
  assign osc_ok_o = (warm == 5'h1F);
endmodule : rco_far_side

/* tb.sv */
`timescale 1ns/1ps
module tb;
  import rco_pkg::*;
  logic mclk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, dump_req = 0, lv_mid = 0;
  logic pwr_fail = 1, pin_low = 0, wdt_cmd = 0, lvd, sup_ok, pin, osc_ok, wdt;
  logic sys_rst, run, p15, tick, opt_err, dump_en, nmode;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, pc, v;
  logic [2:0] div;
  int num_errors = 0, comparisons = 0, cycles = 0;
  always #12.5 mclk_i = ~mclk_i;
  rco_far_side u_far (.mclk_i(mclk_i), .pwr_fail_i(pwr_fail), .pin_low_i(pin_low),
    .wdt_cmd_i(wdt_cmd), .lvd_o(lvd), .supply_ok_o(sup_ok), .pin_o(pin), .osc_ok_o(osc_ok),
    .wdt_o(wdt));
  rco_reset_ctrl u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .clk_en_i(1'b1), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata), .lvd_reset_i(lvd),
    .brownout_i(lvd), .wdt_overflow_i(wdt), .reset_pin_i(pin), .supply_ok_i(sup_ok),
    .lv_mid_i(lv_mid), .lv_high_i(1'b0), .osc_ready_i(osc_ok), .rom_dump_req_i(dump_req),
    .sys_reset_o(sys_rst), .cpu_run_o(run), .pc_start_o(pc), .port1_bit5_o(p15),
    .icycle_tick_o(tick), .icycle_div_o(div), .opt_error_o(opt_err),
    .rom_dump_en_o(dump_en), .normal_mode_o(nmode));
  task stop_test;
    if (num_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      stop_test();
    end
  end
  task check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  task cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : cyc
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr <= a;
    wdata <= d;
    wr_i <= 1;
    @(posedge mclk_i);
    wr_i <= 0;
  endtask : wr
  task rd(input logic [7:0] a);
    @(posedge mclk_i);
    addr <= a;
    rd_i <= 1;
    @(posedge mclk_i);
    rd_i <= 0;
    #1 v = rdata;
  endtask : rd
  task wait_run;
    for (int i = 0; i < 500 && run !== 1; i++) cyc(1);
    check({7'h00, run}, 8'h01);
  endtask : wait_run
  task t_power;
    wait_run();
    check(pc, 8'h00);
    rd(RCO_PROGRAM_FLAG_REG_ADDR);
    check(v, 8'h80);
  endtask : t_power
  task t_regs;
    wr(RCO_PROGRAM_FLAG_REG_ADDR, 8'hC7);
    rd(RCO_PROGRAM_FLAG_REG_ADDR);
    check(v, 8'hC7);
    wr(RCO_PROGRAM_FLAG_REG_ADDR, 8'h38);
    rd(RCO_PROGRAM_FLAG_REG_ADDR);
    check(v, 8'h00);
    rd(8'h90);
    check(v, 8'h00);
    lv_mid <= 1;
    cyc(8);
    rd(RCO_PROGRAM_FLAG_REG_ADDR);
    check(v & 8'h30, 8'h10);
  endtask : t_regs
  task t_lvd;
    pwr_fail <= 1;
    cyc(12);
    check({7'h00, sys_rst}, 8'h01);
    rd(RCO_PROGRAM_FLAG_REG_ADDR);
    check(v & 8'h30, 8'h00);
    pwr_fail <= 0;
    lv_mid <= 0;
    wait_run();
    rd(RCO_PROGRAM_FLAG_REG_ADDR);
    check(v, 8'h80);
  endtask : t_lvd
  task t_div;
    int n;
    logic [7:0] cfg [4] = '{8'h10, 8'h00, 8'h01, 8'hA0};
    logic [7:0] exp [4] = '{8'h02, 8'h00, 8'h01, 8'h01};
    for (int i = 0; i < 4; i++) begin
      wr(RCO_CTRL_ADDR, cfg[i]);
      cyc(3);
      check({5'h00, div}, exp[i]);
      check({7'h00, opt_err}, 8'h00);
    end
    wr(RCO_CTRL_ADDR, 8'h13);
    cyc(3);
    for (n = 0; n < 300 && tick !== 1; n++) cyc(1);
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (tick !== 1 && n < 300);
    check(n[7:0], 8'h08);
  endtask : t_div
  task t_pin;
    wr(RCO_CTRL_ADDR, 8'h02);
    pin_low <= 1;
    cyc(10);
    check({6'h00, sys_rst, p15}, 8'h00);
    pin_low <= 0;
    cyc(10);
    check({6'h00, sys_rst, p15}, 8'h01);
    wr(RCO_CTRL_ADDR, 8'h0A);
    pin_low <= 1;
    cyc(10);
    check({7'h00, sys_rst}, 8'h01);
    cyc(200);
    check({6'h00, sys_rst, run}, 8'h02);
    pin_low <= 0;
    wait_run();
    rd(RCO_PROGRAM_FLAG_REG_ADDR);
    check(v, 8'hC0);
  endtask : t_pin
  task t_wdt;
    wdt_cmd <= 1;
    cyc(4);
    wdt_cmd <= 0;
    cyc(8);
    check({7'h00, sys_rst}, 8'h01);
    wait_run();
    check({7'h00, nmode}, 8'h01);
    rd(RCO_PROGRAM_FLAG_REG_ADDR);
    check(v, 8'h00);
  endtask : t_wdt
  task t_secure;
    dump_req <= 1;
    cyc(4);
    check({7'h00, dump_en}, 8'h01);
    wr(RCO_CTRL_ADDR, 8'h06);
    cyc(4);
    check({7'h00, dump_en}, 8'h00);
    wr(RCO_CTRL_ADDR, 8'h02);
    cyc(4);
    check({7'h00, dump_en}, 8'h00);
  endtask : t_secure
  initial begin
    repeat (6) @(posedge mclk_i);
    rst_i <= 0;
    pwr_fail <= 0;
    t_power();
    t_regs();
    t_lvd();
    t_div();
    t_pin();
    t_wdt();
    t_secure();
    stop_test();
  end
endmodule : tb
